// *** core/afecf_regs.sv ***
// Channel-function register group behind the serial port, with test-pattern data path
//
// Summary of operation
// - Power field 00 runs the chip, 01 powers it fully down and 11 holds it in reset.
// - Clock register bit 0 turns the duty-cycle stabilizer on when 1 (reset value) for all channels.
// - The four-bit input field picks the active channel set, A only after reset.
// - Input register bit 6 at 0 sleeps channels outside the active set, at 1 keeps them powered.
// - User test mode 00/01 repeats single/alternating user words, 10/11 plays them once.
// - Test register bit 5 holds the long pseudo-random generator in reset while 1.
// - Test register bit 4 holds the short pseudo-random generator in reset while 1.
// - The test pattern code picks off, fixed words, checkerboard, sequences, toggles, user, sync and walking bit.
// - With a pattern selected a channel puts test words on its data output instead of samples.
// - Per-channel writes land only in channels whose bit is set in the index register, all four after reset.
// - Writing the transfer bit copies the shifted-in master values to the working registers.
`timescale 1ns/1ps
module afecf_regs
  import afecf_pkg::*;
#(
  parameter int unsigned DATA_W = afecf_pkg::DW
)
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         spi_sclk_i,
  input  wire logic                         spi_csb_n_i,
  input  wire logic                         spi_sdio_i,
  output logic                              spi_sdio_o,
  output logic                              spi_sdio_oe_n_o,
  input  wire logic [NCH-1:0][DATA_W-1:0]   sample_i,
  input  wire logic                         sample_valid_i,
  input  wire logic [DATA_W-1:0]            user_pat1_i,
  input  wire logic [DATA_W-1:0]            user_pat2_i,
  output logic [NCH-1:0][DATA_W-1:0]        data_o,
  output logic                              data_valid_o,
  output afecf_pkg::afecf_status_t          status_o
);
  import afecf_pkg::*;

  // Pin synchronisers: stage 1 feeds stage 2 only
  logic [2:0] sclk_s;
  logic [1:0] csb_s;
  logic [1:0] sdio_s;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_s <= 3'h0;
      csb_s  <= 2'h3;
      sdio_s <= 2'h0;
    end
    else if (ce_i)
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk_i};
      csb_s  <= {csb_s[0], spi_csb_n_i};
      sdio_s <= {sdio_s[0], spi_sdio_i};
    end
  end

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_idle   = csb_s[1];
  wire sdio_bit  = sdio_s[1];

  // Master (shifted-in) and working copies
  logic [7:0]            filler_q;
  logic [NCH-1:0]        index_q;
  logic [1:0]            pwr_m_q;
  logic                  dcs_m_q;
  afecf_mux_t            mux_m_q;
  afecf_test_t [NCH-1:0] test_m_q;
  logic [1:0]            pwr_s_q;
  logic                  dcs_s_q;
  afecf_mux_t            mux_s_q;
  afecf_test_t [NCH-1:0] test_s_q;

  // Serial engine
  afecf_spi_st_t st_q;
  logic [4:0]    bit_cnt_q;
  logic [15:0]   shift_q;
  logic          rd_q;
  logic [7:0]    addr_q;
  logic [7:0]    rd_shift_q;
  logic          sdio_q;
  logic          oe_n_q;

  wire [15:0] shift_nx  = {shift_q[14:0], sdio_bit};
  wire        instr_end = (st_q == ST_INSTR) && sclk_rise && (bit_cnt_q == INSTR_BITS - 5'h1);
  wire        byte_end  = (st_q == ST_DATA) && sclk_rise && (bit_cnt_q == {1'b0, BYTE_BITS} - 5'h1);
  wire        wr_stb    = byte_end && !rd_q;
  wire [7:0]  wr_data   = shift_nx[7:0];
  wire [7:0]  rd_addr   = instr_end ? shift_nx[7:0] : addr_q + 8'h1;
  wire        xfer      = wr_stb && (addr_q == OFS_UPDATE) && wr_data[UPD_XFER_BIT];

  // Reads of the per-channel register show the lowest selected channel
  wire [1:0] rd_ch = index_q[0] ? 2'd0 : index_q[1] ? 2'd1 : index_q[2] ? 2'd2 : index_q[3] ? 2'd3 : 2'd0;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      OFS_RESERVED: r = filler_q;
      OFS_INDEX:    r = {4'h0, index_q};
      OFS_POWER:    r = {6'h00, pwr_m_q};
      OFS_CLOCK:    r = {7'h00, dcs_m_q};
      OFS_INPUT:    r = mux_m_q;
      OFS_TEST:     r = test_m_q[rd_ch];
      default:      r = 8'h00;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q       <= ST_IDLE;
      bit_cnt_q  <= 5'h0;
      shift_q    <= 16'h0000;
      rd_q       <= 1'b0;
      addr_q     <= 8'h00;
      rd_shift_q <= 8'h00;
      sdio_q     <= 1'b0;
      oe_n_q     <= 1'b1;
    end
    else if (ce_i)
    begin
      if (cs_idle)
      begin
        st_q      <= ST_IDLE;
        bit_cnt_q <= 5'h0;
        oe_n_q    <= 1'b1;
      end
      else
      begin
        unique case (st_q)
          ST_IDLE:
          begin
            st_q      <= ST_INSTR;
            bit_cnt_q <= 5'h0;
          end
          ST_INSTR:
          begin
            if (sclk_rise)
            begin
              shift_q   <= shift_nx;
              bit_cnt_q <= bit_cnt_q + 5'h1;
            end
            if (instr_end)
            begin
              st_q       <= ST_DATA;
              bit_cnt_q  <= 5'h0;
              rd_q       <= shift_nx[15];
              addr_q     <= shift_nx[7:0];
              rd_shift_q <= rd_byte(shift_nx[7:0]);
            end
          end
          ST_DATA:
          begin
            if (sclk_rise)
            begin
              shift_q   <= shift_nx;
              bit_cnt_q <= bit_cnt_q + 5'h1;
            end
            if (byte_end)
            begin
              bit_cnt_q <= 5'h0;
              addr_q    <= addr_q + 8'h1;
              if (rd_q)
                rd_shift_q <= rd_byte(rd_addr);
            end
            else if (sclk_fall && rd_q)
            begin
              sdio_q     <= rd_shift_q[7];
              rd_shift_q <= {rd_shift_q[6:0], 1'b0};
              oe_n_q     <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Register writes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      filler_q <= RST_RESERVED;
      index_q  <= RST_INDEX[NCH-1:0];
      pwr_m_q  <= RST_POWER[1:0];
      dcs_m_q  <= RST_CLOCK[CLK_DCS_BIT];
      mux_m_q  <= RST_INPUT;
      test_m_q <= {NCH{RST_TEST}};
    end
    else if (ce_i && wr_stb)
    begin
      case (addr_q)
        OFS_RESERVED: filler_q <= wr_data;
        OFS_INDEX:    index_q  <= wr_data[NCH-1:0];
        OFS_POWER:    pwr_m_q  <= wr_data[1:0];
        OFS_CLOCK:    dcs_m_q  <= wr_data[CLK_DCS_BIT];
        OFS_INPUT:    mux_m_q  <= wr_data;
        OFS_TEST:
          for (int c = 0; c < NCH; c++)
            if (index_q[c])
              test_m_q[c] <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_s_q  <= RST_POWER[1:0];
      dcs_s_q  <= RST_CLOCK[CLK_DCS_BIT];
      mux_s_q  <= RST_INPUT;
      test_s_q <= {NCH{RST_TEST}};
    end
    else if (ce_i && xfer)
    begin
      pwr_s_q  <= pwr_m_q;
      dcs_s_q  <= dcs_m_q;
      mux_s_q  <= mux_m_q;
      test_s_q <= test_m_q;
    end
  end

  // Status decode
  wire [4:0] act_mask   = active_mask(mux_s_q.sel);
  wire       pwr_run    = (pwr_s_q == PWR_RUN) || (pwr_s_q == PWR_RSVD);
  wire       pwr_down   = (pwr_s_q == PWR_DOWN);
  wire       pwr_reset  = (pwr_s_q == PWR_RESET);
  wire [4:0] pwr_mask   = pwr_run ? (mux_s_q.unused_channel_sleep ? 5'h1F : act_mask) : 5'h00;

  // Generators common to every channel; hold if any channel asks
  logic [DATA_W-1:0] pn_long;
  logic [DATA_W-1:0] pn_short;
  logic              long_hold;
  logic              short_hold;

  always_comb
  begin
    long_hold  = 1'b0;
    short_hold = 1'b0;
    for (int c = 0; c < NCH; c++)
    begin
      long_hold  = long_hold | test_s_q[c].pn_long_rst;
      short_hold = short_hold | test_s_q[c].pn_short_rst;
    end
  end

  afecf_pn_gen u_pn (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .step_i       (sample_valid_i),
    .long_hold_i  (long_hold),
    .short_hold_i (short_hold),
    .long_o       (pn_long),
    .short_o      (pn_short)
  );

  // Phase of alternating patterns and the walking one
  logic              phase_q;
  logic [DATA_W-1:0] walk_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_q <= 1'b0;
      walk_q  <= WALK_SEED;
    end
    else if (ce_i && sample_valid_i)
    begin
      phase_q <= ~phase_q;
      walk_q  <= {walk_q[DATA_W-2:0], walk_q[DATA_W-1]};
    end
  end

  function automatic logic [DATA_W-1:0] pick(input afecf_pat_t p, input logic ph,
                                             input logic [DATA_W-1:0] smp, input logic [DATA_W-1:0] usr);
    logic [DATA_W-1:0] w;
    w = smp;
    case (p)
      PAT_MIDSCALE: w = PAT_MID;
      PAT_POSFS:    w = PAT_POS;
      PAT_NEGFS:    w = PAT_NEG;
      PAT_CHECKER:  w = ph ? PAT_CHK_B : PAT_CHK_A;
      PAT_PN_LONG:  w = pn_long;
      PAT_PN_SHORT: w = pn_short;
      PAT_WORD_TOG: w = ph ? PAT_NEG : PAT_POS;
      PAT_USER:     w = usr;
      PAT_BIT_TOG:  w = ph ? PAT_BIT_B : PAT_BIT_A;
      PAT_SYNC_W:   w = PAT_SYNC;
      PAT_ONE_HIGH: w = walk_q;
      PAT_MIXED_F:  w = PAT_MIXED;
      default:      w = smp;
    endcase
    return w;
  endfunction

  // Per-channel output words
  logic [NCH-1:0][1:0] once_q;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    wire        alt       = test_s_q[c].user_mode[0];
    wire        once      = test_s_q[c].user_mode[1];
    wire        once_done = once && (once_q[c] == (alt ? 2'd2 : 2'd1));
    wire        usr_sel   = once ? (alt && once_q[c][0]) : (alt && phase_q);
    wire [DATA_W-1:0] usr = usr_sel ? user_pat2_i : user_pat1_i;
    wire afecf_pat_t  pat = (test_s_q[c].pattern == PAT_USER && once_done) ? PAT_OFF
                          : afecf_pat_t'(test_s_q[c].pattern);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        once_q[c] <= 2'd0;
        data_o[c] <= '0;
      end
      else if (ce_i)
      begin
        if (xfer)
          once_q[c] <= 2'd0;
        else if (sample_valid_i && once && !once_done && pat == PAT_USER)
          once_q[c] <= once_q[c] + 2'd1;
        if (sample_valid_i)
          data_o[c] <= pick(pat, phase_q, sample_i[c], usr);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_valid_o    <= 1'b0;
      status_o        <= '0;
      spi_sdio_o      <= 1'b0;
      spi_sdio_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      data_valid_o    <= sample_valid_i;
      status_o        <= '{run: pwr_run, power_down: pwr_down, in_reset: pwr_reset,
                           dcs_en: dcs_s_q, active: act_mask, powered: pwr_mask};
      spi_sdio_o      <= sdio_q;
      spi_sdio_oe_n_o <= oe_n_q | cs_idle;
    end
  end

endmodule // afecf_regs

// *** core/afecf_pkg.sv ***
// Package for the channel-function register group: offsets, resets, layouts, codes
package afecf_pkg;

  localparam int unsigned DW       = 12;
  localparam int unsigned NCH      = 4;
  localparam int unsigned LONG_W   = 23;
  localparam int unsigned SHORT_W  = 9;

  // Register offsets
  localparam logic [7:0] OFS_RESERVED = 8'h04;
  localparam logic [7:0] OFS_INDEX    = 8'h05;
  localparam logic [7:0] OFS_POWER    = 8'h08;
  localparam logic [7:0] OFS_CLOCK    = 8'h09;
  localparam logic [7:0] OFS_INPUT    = 8'h0C;
  localparam logic [7:0] OFS_TEST     = 8'h0D;
  localparam logic [7:0] OFS_UPDATE   = 8'hFF;

  // Values after reset
  localparam logic [7:0] RST_RESERVED = 8'h0F;
  localparam logic [7:0] RST_INDEX    = 8'h0F;
  localparam logic [7:0] RST_POWER    = 8'h00;
  localparam logic [7:0] RST_CLOCK    = 8'h01;
  localparam logic [7:0] RST_INPUT    = 8'h00;
  localparam logic [7:0] RST_TEST     = 8'h00;

  // Field positions
  localparam int unsigned CLK_DCS_BIT  = 0;
  localparam int unsigned UPD_XFER_BIT = 0;

  // Serial frame counts
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // Fixed test words
  localparam logic [DW-1:0] PAT_MID    = 12'h800;
  localparam logic [DW-1:0] PAT_POS    = 12'hFFF;
  localparam logic [DW-1:0] PAT_NEG    = 12'h000;
  localparam logic [DW-1:0] PAT_CHK_A  = 12'hAAA;
  localparam logic [DW-1:0] PAT_CHK_B  = 12'h555;
  localparam logic [DW-1:0] PAT_BIT_A  = 12'h001;
  localparam logic [DW-1:0] PAT_BIT_B  = 12'h000;
  localparam logic [DW-1:0] PAT_SYNC   = 12'h03F;
  localparam logic [DW-1:0] PAT_MIXED  = 12'hA0F;
  localparam logic [DW-1:0] WALK_SEED  = 12'h001;
  localparam logic [LONG_W-1:0]  LONG_SEED  = 23'h7FFFFF;
  localparam logic [SHORT_W-1:0] SHORT_SEED = 9'h1FF;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_DOWN  = 2'b01,
    PWR_RSVD  = 2'b10,
    PWR_RESET = 2'b11
  } afecf_pwr_t;

  typedef enum logic [3:0] {
    PAT_OFF      = 4'h0,
    PAT_MIDSCALE = 4'h1,
    PAT_POSFS    = 4'h2,
    PAT_NEGFS    = 4'h3,
    PAT_CHECKER  = 4'h4,
    PAT_PN_LONG  = 4'h5,
    PAT_PN_SHORT = 4'h6,
    PAT_WORD_TOG = 4'h7,
    PAT_USER     = 4'h8,
    PAT_BIT_TOG  = 4'h9,
    PAT_SYNC_W   = 4'hA,
    PAT_ONE_HIGH = 4'hB,
    PAT_MIXED_F  = 4'hC
  } afecf_pat_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b100
  } afecf_spi_st_t;

  typedef struct packed {
    logic [1:0] user_mode;
    logic       pn_long_rst;
    logic       pn_short_rst;
    logic [3:0] pattern;
  } afecf_test_t;

  typedef struct packed {
    logic       rsvd7;
    logic       unused_channel_sleep;
    logic [1:0] rsvd54;
    logic [3:0] sel;
  } afecf_mux_t;

  // Status bundle; channel order {aux, D, C, B, A}
  typedef struct packed {
    logic       run;
    logic       power_down;
    logic       in_reset;
    logic       dcs_en;
    logic [4:0] active;
    logic [4:0] powered;
  } afecf_status_t;

  function automatic logic [4:0] active_mask(input logic [3:0] sel);
    logic [4:0] m;
    m = 5'h01;
    case (sel)
      4'h1: m = 5'h10;
      4'h2: m = 5'h03;
      4'h3: m = 5'h11;
      4'h4: m = 5'h07;
      4'h5: m = 5'h13;
      4'h6: m = 5'h0F;
      4'h7: m = 5'h17;
      default: m = 5'h01;
    endcase
    return m;
  endfunction

endpackage

// *** core/afecf_pn_gen.sv ***
// Long and short pseudo-random generators shared by all channels
`timescale 1ns/1ps
module afecf_pn_gen
  import afecf_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          step_i,
  input  wire logic          long_hold_i,
  input  wire logic          short_hold_i,
  output logic [DW-1:0]      long_o,
  output logic [DW-1:0]      short_o
);

  logic [LONG_W-1:0]  long_q;
  logic [SHORT_W-1:0] short_q;
  wire                long_fb  = long_q[22] ^ long_q[17];
  wire                short_fb = short_q[8] ^ short_q[4];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      long_q  <= LONG_SEED;
      short_q <= SHORT_SEED;
    end
    else if (ce_i)
    begin
      if (long_hold_i)
        long_q <= LONG_SEED;
      else if (step_i)
        long_q <= {long_q[LONG_W-2:0], long_fb};
      if (short_hold_i)
        short_q <= SHORT_SEED;
      else if (step_i)
        short_q <= {short_q[SHORT_W-2:0], short_fb};
    end
  end

  assign long_o  = long_q[DW-1:0];
  assign short_o = {short_q, short_q[8:6]};

endmodule // afecf_pn_gen

// *** bench/afecf_regs_properties.sv ***
// Port checker for the channel-function register group
`timescale 1ns/1ps
module afecf_regs_chk
  import afecf_pkg::*;
#(
  parameter int unsigned DATA_W = afecf_pkg::DW
)
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       ce_i,
  input wire logic                       spi_csb_n_i,
  input wire logic                       spi_sdio_oe_n_o,
  input wire logic                       sample_valid_i,
  input wire logic [NCH-1:0][DATA_W-1:0] data_o,
  input wire logic                       data_valid_o,
  input wire afecf_pkg::afecf_status_t   status_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_valid; ce_i && sample_valid_i |=> data_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("valid strobe not passed on");
  property p_quiet; ce_i && !sample_valid_i |=> !data_valid_o; endproperty
  a_quiet: assert property (p_quiet) else $error("valid strobe without cause");
  // Settled config only, though a transfer moves no word until the next sample strobe
  property p_hold; spi_csb_n_i [*8] ##0 !sample_valid_i |=> $stable(data_o); endproperty
  a_hold: assert property (p_hold) else $error("output word moved without sample");
  property p_mode; !$past(rst_i) |-> $onehot({status_o.run, status_o.power_down, status_o.in_reset});
  endproperty
  a_mode: assert property (p_mode) else $error("power state not one of three");
  property p_act;
    !$past(rst_i) |-> status_o.active inside {5'h01, 5'h10, 5'h03, 5'h11, 5'h07, 5'h13, 5'h0F, 5'h17};
  endproperty
  a_act: assert property (p_act) else $error("illegal active channel set");
  property p_pwr; status_o.run |-> (status_o.active & ~status_o.powered) == 5'h00; endproperty
  a_pwr: assert property (p_pwr) else $error("active channel not powered");
  property p_oe; spi_csb_n_i [*5] |-> spi_sdio_oe_n_o; endproperty
  a_oe: assert property (p_oe) else $error("data pin driven while deselected");
  property p_still; spi_csb_n_i [*8] |-> $stable(status_o); endproperty
  a_still: assert property (p_still) else $error("status changed outside a frame");
endmodule // afecf_regs_chk

bind afecf_regs afecf_regs_chk #(.DATA_W(DATA_W)) afecf_regs_chk_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .spi_csb_n_i(spi_csb_n_i), .spi_sdio_oe_n_o(spi_sdio_oe_n_o), .sample_valid_i(sample_valid_i),
  .data_o(data_o), .data_valid_o(data_valid_o), .status_o(status_o));

// *** bench/afecf_host.sv ***
// Serial host model that frames register reads and writes
`timescale 1ns/1ps
module afecf_host
#(
  parameter int unsigned HALF = 8
)
(
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      csb_n_o,
  output logic      sdio_o,
  input  wire logic sdio_i
);
  initial
  begin
    sclk_o  = 1'b0;
    csb_n_o = 1'b1;
    sdio_o  = 1'b0;
  end
  // Sample at end of low phase, well after the device's output lag
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    sdio_o <= b;
    repeat (HALF) @(posedge clk_i);
    r = sdio_i;
    sclk_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask
  task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] sh;
    logic        r;
    sh = {rd, 7'h00, a, d};
    q  = 8'h00;
    @(posedge clk_i);
    csb_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      // Released line toggles so a stale level cannot pass as data
      bit_io((i < 8 && rd) ? ~sdio_o : sh[i], r);
      if (i < 8)
        q[i] = r;
    end
    repeat (HALF) @(posedge clk_i);
    csb_n_o <= 1'b1;
    sclk_o  <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
endmodule // afecf_host

// *** bench/tb_afecf_regs.sv ***
// Self-checking bench for the channel-function register group
`timescale 1ns/1ps
module tb_afecf_regs;
  import afecf_pkg::*;
  localparam logic [4:0] MASK [8] = '{5'h01, 5'h10, 5'h03, 5'h11, 5'h07, 5'h13, 5'h0F, 5'h17};
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   valid = 1'b0;
  logic                   ce    = 1'b1;
  logic [NCH-1:0][DW-1:0] smp   = {12'h444, 12'h333, 12'h222, 12'h111};
  logic [DW-1:0]          pat1  = 12'h5A1;
  logic [DW-1:0]          pat2  = 12'h0C3;
  logic                   sclk, csb_n, host_d, sdio_q, oe_n, dv;
  wire logic              sdio  = oe_n ? host_d : sdio_q;
  logic [NCH-1:0][DW-1:0] dout;
  afecf_status_t          st;
  logic [7:0]             rd;
  int                     fails    = 0;
  int                     n_checks = 0;
  always #5 clk_i = ~clk_i;
  afecf_host afecf_host_i (.clk_i(clk_i), .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(host_d), .sdio_i(sdio));
  afecf_regs afecf_regs_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .spi_sclk_i(sclk), .spi_csb_n_i(csb_n),
    .spi_sdio_i(sdio), .spi_sdio_o(sdio_q), .spi_sdio_oe_n_o(oe_n), .sample_i(smp), .sample_valid_i(valid),
    .user_pat1_i(pat1), .user_pat2_i(pat2), .data_o(dout), .data_valid_o(dv), .status_o(st));
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    afecf_host_i.frame(1'b0, a, d, rd);
  endtask
  task automatic rdb(input logic [7:0] a);
    afecf_host_i.frame(1'b1, a, 8'h00, rd);
  endtask
  task automatic xfer();
    wr(OFS_UPDATE, 8'h01);
  endtask
  task automatic pulse();
    @(posedge clk_i);
    valid <= 1'b1;
    @(posedge clk_i);
    valid <= 1'b0;
    #1;
    chk_word("valid out", 12'h001, {11'h000, dv});
  endtask
  task automatic t_reset();
    logic [7:0] ad [8];
    logic [7:0] ex [8];
    ad = '{OFS_RESERVED, OFS_INDEX, OFS_POWER, OFS_CLOCK, OFS_INPUT, OFS_TEST, 8'h06, OFS_UPDATE};
    ex = '{8'h0F, 8'h0F, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    chk_word("run", 12'h001, {11'h000, st.run});
    chk_word("dcs", 12'h001, {11'h000, st.dcs_en});
    chk_word("active", 12'h001, {7'h00, st.active});
    chk_word("powered", 12'h001, {7'h00, st.powered});
    for (int i = 0; i < 8; i++)
    begin
      rdb(ad[i]);
      chk_byte("reset value", ex[i], rd);
    end
    wr(OFS_RESERVED, 8'h00);
    rdb(OFS_RESERVED);
    chk_byte("filler", 8'h00, rd);
    $display("done reset");
  endtask
  task automatic t_power();
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_POWER, 8'(i));
      xfer();
      chk_word("run", {11'h000, i == 0 || i == 2}, {11'h000, st.run});
      chk_word("down", {11'h000, i == 1}, {11'h000, st.power_down});
      chk_word("reset", {11'h000, i == 3}, {11'h000, st.in_reset});
    end
    wr(OFS_POWER, 8'h00);
    xfer();
    wr(OFS_CLOCK, 8'h00);
    chk_word("dcs before", 12'h001, {11'h000, st.dcs_en});
    xfer();
    chk_word("dcs off", 12'h000, {11'h000, st.dcs_en});
    wr(OFS_CLOCK, 8'h01);
    xfer();
    chk_word("dcs on", 12'h001, {11'h000, st.dcs_en});
    $display("done power");
  endtask
  task automatic t_mux();
    logic [3:0] m;
    logic [4:0] a;
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      // Codes above 7 are undefined and fall back to A only
      a = m[3] ? 5'h01 : MASK[m[2:0]];
      wr(OFS_INPUT, {1'b0, m[0], 2'h0, m});
      xfer();
      chk_word("active", {7'h00, a}, {7'h00, st.active});
      chk_word("powered", {7'h00, m[0] ? 5'h1F : a}, {7'h00, st.powered});
    end
    wr(OFS_INPUT, 8'h00);
    xfer();
    $display("done mux");
  endtask
  task automatic t_pat();
    logic [3:0]    pc [8];
    logic [DW-1:0] pe [8];
    logic [3:0]    tc [3];
    logic [DW-1:0] te [3];
    logic [DW-1:0] w0;
    pc = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'hC, 4'hD};
    pe = '{smp[0], PAT_MID, PAT_POS, PAT_NEG, pat1, PAT_SYNC, PAT_MIXED, smp[0]};
    tc = '{4'h4, 4'h7, 4'h9};
    te = '{PAT_CHK_A ^ PAT_CHK_B, PAT_POS ^ PAT_NEG, PAT_BIT_A ^ PAT_BIT_B};
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_TEST, {4'h0, pc[i]});
      xfer();
      pulse();
      chk_word("pattern a", pe[i], dout[0]);
      chk_word("pattern d", (i == 0 || i == 7) ? smp[3] : pe[i], dout[3]);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_TEST, {4'h0, tc[i]});
      xfer();
      pulse();
      w0 = dout[0];
      pulse();
      chk_word("toggle", te[i], w0 ^ dout[0]);
    end
    wr(OFS_TEST, 8'h0B);
    xfer();
    pulse();
    w0 = dout[0];
    pulse();
    chk_word("one bit", 12'h001, {11'h000, $onehot(w0)});
    chk_word("one high", {w0[DW-2:0], w0[DW-1]}, dout[0]);
    // Enable low must swallow a strobe without stepping anything
    w0 = dout[0];
    @(posedge clk_i);
    ce    <= 1'b0;
    valid <= 1'b1;
    @(posedge clk_i);
    valid <= 1'b0;
    @(posedge clk_i);
    ce    <= 1'b1;
    #1;
    chk_word("frozen word", w0, dout[0]);
    chk_word("frozen valid", 12'h000, {11'h000, dv});
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_TEST, k ? 8'h16 : 8'h25);
      xfer();
      pulse();
      w0 = dout[0];
      pulse();
      chk_word("pn held", w0, dout[0]);
      wr(OFS_TEST, k ? 8'h06 : 8'h05);
      xfer();
      pulse();
      w0 = dout[0];
      pulse();
      chk_word("pn runs", 12'h001, {11'h000, w0 !== dout[0]});
    end
    $display("done pattern");
  endtask
  task automatic t_user();
    logic [DW-1:0] w [3];
    logic [DW-1:0] e [3];
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_TEST, {m[1:0], 6'h08});
      xfer();
      for (int k = 0; k < 3; k++)
      begin
        pulse();
        w[k] = dout[0];
      end
      case (m)
        0: e = '{pat1, pat1, pat1};
        1: e = '{w[0] === pat2 ? pat2 : pat1, w[0] === pat2 ? pat1 : pat2, w[0] === pat2 ? pat2 : pat1};
        2: e = '{pat1, smp[0], smp[0]};
        default: e = '{pat1, pat2, smp[0]};
      endcase
      for (int k = 0; k < 3; k++)
        chk_word("user word", e[k], w[k]);
    end
    wr(OFS_TEST, 8'h00);
    xfer();
    wr(OFS_INDEX, 8'h02);
    wr(OFS_TEST, 8'h02);
    xfer();
    rdb(OFS_TEST);
    chk_byte("index read", 8'h02, rd);
    pulse();
    chk_word("chan b", PAT_POS, dout[1]);
    chk_word("chan a", smp[0], dout[0]);
    wr(OFS_INDEX, 8'h0F);
    $display("done user");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Roughly twice the expected run length
  initial
  begin
    #900000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    t_reset();
    t_power();
    t_mux();
    t_pat();
    t_user();
    summarize();
  end
endmodule // tb_afecf_regs
